// ===== rtl/uphc_pkg.sv
// package for the usb pipe handshake control block
package uphc_pkg;

  // ****************************************
  // apb register map
  // ****************************************
  localparam logic [7:0] UPHC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] UPHC_PERI_OFS   = 8'h04;
  localparam logic [7:0] UPHC_STAT_OFS   = 8'h08;
  localparam logic [7:0] UPHC_MAX_PACKET_SIZE_FIELD_OFS   = 8'h0c;

  // ctrl field positions
  localparam int UPHC_CTRL_ROLE  = 0;
  localparam int UPHC_CTRL_TYPE  = 1;
  localparam int UPHC_CTRL_DIR   = 3;
  localparam int UPHC_CTRL_RESP  = 4;
  localparam int UPHC_CTRL_ACLR  = 6;
  localparam int UPHC_CTRL_TCLR  = 7;
  localparam int UPHC_CTRL_BUS_ACTIVITY_ENABLE  = 8;
  localparam int UPHC_CTRL_DBUF  = 9;
  localparam int UPHC_CTRL_CONT  = 10;

  // status field positions
  localparam int UPHC_STAT_OVERRUN_FLAG  = 0;
  localparam int UPHC_STAT_IVAL  = 1;
  localparam int UPHC_STAT_MXOV  = 2;
  localparam int UPHC_STAT_CRC   = 3;
  localparam int UPHC_STAT_PING  = 4;

  // reset values and split max packet size limit
  localparam logic [31:0] UPHC_CTRL_RST = 32'h0000_0000;
  localparam logic [3:0]  UPHC_INTERVAL_EXPONENT_RST = 4'h0;
  localparam logic [10:0] UPHC_MAX_PACKET_SIZE_FIELD_RST = 11'h040;
  localparam logic [10:0] UPHC_SPLIT_MAX_PACKET_SIZE_FIELD_MAX = 11'h0bc;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    UPHC_RESP_NAK   = 2'h0,
    UPHC_RESP_BUF   = 2'h1,
    UPHC_RESP_STALL = 2'h2
  } uphc_resp_e;

  typedef enum logic [1:0] {
    UPHC_XT_BULK = 2'h0,
    UPHC_XT_INTR = 2'h1,
    UPHC_XT_ISO  = 2'h2
  } uphc_xfer_e;

  typedef enum logic [2:0] {
    UPHC_TK_NONE  = 3'h0,
    UPHC_TK_SETUP = 3'h1,
    UPHC_TK_IN    = 3'h2,
    UPHC_TK_OUT   = 3'h3,
    UPHC_TK_PING  = 3'h4
  } uphc_tok_e;

  typedef enum logic [2:0] {
    UPHC_HS_NONE  = 3'h0,
    UPHC_HS_ACK   = 3'h1,
    UPHC_HS_NAK   = 3'h2,
    UPHC_HS_STALL = 3'h3,
    UPHC_HS_NYET  = 3'h4,
    UPHC_HS_DATA  = 3'h5,
    UPHC_HS_ZLP   = 3'h6
  } uphc_hs_e;

  typedef enum logic [1:0] {
    UPHC_ST_PING = 2'b01,
    UPHC_ST_OUT  = 2'b10
  } uphc_host_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    uphc_tok_e   tok;
    logic        short_pkt;
    logic        pid_err;
    logic        crc_err;
    logic [10:0] len;
  } uphc_rx_s;

  typedef struct packed {
    logic        space_two;
    logic        space_one;
    logic        has_data;
  } uphc_buf_s;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0]  interval_exponent;
    logic [10:0] max_packet_size_field;
    logic [4:0]  stat;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    uphc_host_e  hst;
    logic [15:0] icnt;
    logic        iv_seen;
    logic        iv_tick;
    uphc_hs_e    resp;
    logic        resp_v;
    uphc_tok_e   issue;
    logic        issue_v;
    logic        not_ready_interrupt;
  } uphc_state_s;

endpackage : uphc_pkg

// ===== rtl/uphc_core.sv
// usb pipe handshake control: responses, ping sequencing, interval, iso errors
`timescale 1ns/100ps
`default_nettype none

module uphc_core import uphc_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // link events
  input  wire uphc_rx_s    rx_i,
  input  wire logic [2:0]  hs_rx_i,
  input  wire logic        sof_i,
  input  wire logic        bus_reset_i,
  input  wire uphc_buf_s   buf_i,
  // link answers
  output uphc_hs_e         resp_o,
  output logic             resp_v_o,
  output uphc_tok_e        issue_o,
  output logic             issue_v_o,
  output logic             not_ready_interrupt_o,
  output logic             interval_point_o
);

  initial begin
    if (CNT_W < 16 || CNT_W > 16) $error("CNT_W must be 16");
  end

  uphc_state_s q, d;

  logic        role_host;
  uphc_xfer_e  xt;
  logic        dir_in;
  uphc_resp_e  rsp;
  logic        apb_acc;
  logic [15:0] ilen;
  logic        fin_hs;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [15:0] uphc_len(input logic [3:0] e);
    uphc_len = 16'h0001 << e;
  endfunction : uphc_len

  assign role_host = q.ctrl[UPHC_CTRL_ROLE];
  assign xt        = uphc_xfer_e'(q.ctrl[UPHC_CTRL_TYPE +: 2]);
  assign dir_in    = q.ctrl[UPHC_CTRL_DIR];
  assign rsp       = uphc_resp_e'(q.ctrl[UPHC_CTRL_RESP +: 2]);
  assign apb_acc   = psel_i && penable_i && !q.pready;
  assign ilen      = uphc_len(q.interval_exponent);
  assign fin_hs    = hs_rx_i != 3'h0;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.pready  = apb_acc;
    d.pslverr = 1'b0;
    d.resp_v  = 1'b0;
    d.issue_v = 1'b0;
    d.iv_tick = 1'b0;
    d.not_ready_interrupt    = 1'b0;
    // apb access, one wait state
    if (apb_acc) begin
      if (pwrite_i) begin
        unique case (paddr_i)
          UPHC_CTRL_OFS: d.ctrl = {21'h0, pwdata_i[10:0]};
          UPHC_PERI_OFS: d.interval_exponent = pwdata_i[3:0];
          UPHC_MAX_PACKET_SIZE_FIELD_OFS: d.max_packet_size_field = pwdata_i[10:0];
          UPHC_STAT_OFS: d.stat = q.stat & ~pwdata_i[4:0];
          default:       d.pslverr = 1'b1;
        endcase
      end else begin
        unique case (paddr_i)
          UPHC_CTRL_OFS: d.prdata = q.ctrl;
          UPHC_PERI_OFS: d.prdata = {28'h0, q.interval_exponent};
          UPHC_MAX_PACKET_SIZE_FIELD_OFS: d.prdata = {21'h0, q.max_packet_size_field};
          UPHC_STAT_OFS: d.prdata = {27'h0, q.stat};
          default: begin
            d.prdata  = 32'h0;
            d.pslverr = 1'b1;
          end
        endcase
      end
    end
    d.stat[UPHC_STAT_PING] = (q.hst == UPHC_ST_PING);

    // interval counter, host timing and peripheral windows
    if (q.ctrl[UPHC_CTRL_ACLR]) begin
      d.icnt = 16'h0;
    end else if (sof_i && q.ctrl[UPHC_CTRL_BUS_ACTIVITY_ENABLE] && !bus_reset_i) begin
      if (q.icnt + 16'h1 >= ilen) begin
        d.icnt    = 16'h0;
        d.iv_tick = 1'b1;
        // close the interval frame: no in token seen is an interval error
        if (!role_host && xt == UPHC_XT_ISO && dir_in && !q.iv_seen) begin
          d.stat[UPHC_STAT_IVAL] = 1'b1;
          d.not_ready_interrupt = 1'b1;
        end
        d.iv_seen = 1'b0;
      end else begin
        d.icnt = q.icnt + 16'h1;
      end
    end

    // host token issue at interval point
    if (role_host && q.iv_tick && xt != UPHC_XT_BULK) begin
      if (xt == UPHC_XT_ISO) begin
        d.issue   = dir_in ? UPHC_TK_IN : UPHC_TK_OUT;
        d.issue_v = 1'b1;
        if ((dir_in && !buf_i.space_one) || (!dir_in && !buf_i.has_data)) begin
          d.stat[UPHC_STAT_OVERRUN_FLAG] = 1'b1;
          d.not_ready_interrupt = 1'b1;
        end
      end else if (rsp == UPHC_RESP_BUF
                   && (dir_in ? buf_i.space_one : buf_i.has_data)) begin
        d.issue   = dir_in ? UPHC_TK_IN : UPHC_TK_OUT;
        d.issue_v = 1'b1;
      end
    end

    // host bulk out ping sequencer
    if (role_host && xt == UPHC_XT_BULK && !dir_in && rsp == UPHC_RESP_BUF
        && buf_i.has_data && !fin_hs) begin
      d.issue   = (q.hst == UPHC_ST_PING) ? UPHC_TK_PING : UPHC_TK_OUT;
      d.issue_v = 1'b1;
    end
    if (role_host && xt == UPHC_XT_BULK && fin_hs) begin
      if (q.hst == UPHC_ST_PING && hs_rx_i == UPHC_HS_ACK) begin
        d.hst = UPHC_ST_OUT;
      end else if (hs_rx_i == UPHC_HS_NAK || hs_rx_i == UPHC_HS_NYET) begin
        d.hst = UPHC_ST_PING;
      end
    end
    // interrupt pipes: nyet counts as ack, nothing further to do
    if (q.ctrl[UPHC_CTRL_TCLR] || q.ctrl[UPHC_CTRL_ACLR]) begin
      d.hst = UPHC_ST_PING;
    end

    // peripheral responses
    if (!role_host && rx_i.tok != UPHC_TK_NONE) begin
      d.resp_v = 1'b1;
      d.resp   = UPHC_HS_NONE;
      if (xt == UPHC_XT_ISO) begin
        if (rx_i.pid_err) begin
          d.resp_v = 1'b0;
        end else if (rx_i.crc_err) begin
          d.resp_v = 1'b0;
          d.stat[UPHC_STAT_CRC] = 1'b1;
        end else if (rx_i.tok == UPHC_TK_IN) begin
          d.iv_seen = 1'b1;
          d.resp = buf_i.has_data ? UPHC_HS_DATA : UPHC_HS_ZLP;
          if (!buf_i.has_data) begin
            d.stat[UPHC_STAT_OVERRUN_FLAG] = 1'b1;
            d.not_ready_interrupt = 1'b1;
          end
        end else begin
          d.resp_v = 1'b0;
          if (!q.iv_tick) begin
            d.stat[UPHC_STAT_IVAL] = 1'b1;
            d.not_ready_interrupt = 1'b1;
          end
          if (rx_i.len > q.max_packet_size_field) begin
            d.stat[UPHC_STAT_MXOV] = 1'b1;
          end else if (!buf_i.space_one) begin
            d.stat[UPHC_STAT_OVERRUN_FLAG] = 1'b1;
            d.not_ready_interrupt = 1'b1;
          end
        end
      end else if (rx_i.tok == UPHC_TK_SETUP) begin
        d.resp = UPHC_HS_ACK;
      end else if (xt == UPHC_XT_INTR && rx_i.tok == UPHC_TK_PING) begin
        d.resp_v = 1'b0;
      end else if (rsp != UPHC_RESP_BUF) begin
        d.resp = (rsp == UPHC_RESP_STALL) ? UPHC_HS_STALL : UPHC_HS_NAK;
      end else if (rx_i.tok == UPHC_TK_IN) begin
        d.resp = buf_i.has_data ? UPHC_HS_DATA : UPHC_HS_NAK;
      end else if (buf_i.space_two) begin
        d.resp = UPHC_HS_ACK;
      end else if (buf_i.space_one) begin
        if (rx_i.tok == UPHC_TK_PING || rx_i.short_pkt || xt == UPHC_XT_INTR) begin
          d.resp = UPHC_HS_ACK;
        end else begin
          d.resp = UPHC_HS_NYET;
        end
      end else begin
        d.resp = UPHC_HS_NAK;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q         <= '0;
      q.ctrl    <= UPHC_CTRL_RST;
      q.interval_exponent    <= UPHC_INTERVAL_EXPONENT_RST;
      q.max_packet_size_field    <= UPHC_MAX_PACKET_SIZE_FIELD_RST;
      q.hst     <= UPHC_ST_PING;
      q.stat    <= 5'h10;
      q.resp    <= UPHC_HS_NONE;
      q.issue   <= UPHC_TK_NONE;
    end else begin
      q <= d;
    end
  end

  assign prdata_o              = q.prdata;
  assign pready_o              = q.pready;
  assign pslverr_o             = q.pslverr;
  assign resp_o                = q.resp;
  assign resp_v_o              = q.resp_v;
  assign issue_o               = q.issue;
  assign issue_v_o             = q.issue_v;
  assign not_ready_interrupt_o = q.not_ready_interrupt;
  assign interval_point_o      = q.iv_tick;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  setup_ack_a: assert property (!role_host && rx_i.tok == UPHC_TK_SETUP && xt != UPHC_XT_ISO
    |=> resp_v_o && resp_o == UPHC_HS_ACK) else $error("setup not acked");
  nyet_one_a: assert property (!role_host && xt == UPHC_XT_BULK && rsp == UPHC_RESP_BUF
    && rx_i.tok == UPHC_TK_OUT && !buf_i.space_two && buf_i.space_one && !rx_i.short_pkt
    |=> resp_o == UPHC_HS_NYET) else $error("missing nyet");
  short_ack_a: assert property (!role_host && xt == UPHC_XT_BULK && rsp == UPHC_RESP_BUF
    && rx_i.tok == UPHC_TK_OUT && !buf_i.space_two && buf_i.space_one && rx_i.short_pkt
    |=> resp_o == UPHC_HS_ACK) else $error("short not acked");
  nak_full_a: assert property (!role_host && xt != UPHC_XT_ISO && rsp == UPHC_RESP_BUF
    && rx_i.tok == UPHC_TK_OUT && !buf_i.space_one |=> resp_o == UPHC_HS_NAK)
    else $error("full not naked");
  intr_ping_a: assert property (!role_host && xt == UPHC_XT_INTR && rx_i.tok == UPHC_TK_PING
    |=> !resp_v_o) else $error("intr ping answered");
  intr_nyet_a: assert property (!role_host && xt == UPHC_XT_INTR
    |=> !(resp_v_o && resp_o == UPHC_HS_NYET)) else $error("intr nyet");
  ping_back_a: assert property (role_host && xt == UPHC_XT_BULK
    && hs_rx_i == UPHC_HS_NYET ##1 !q.ctrl[UPHC_CTRL_TCLR] |-> q.hst == UPHC_ST_PING)
    else $error("no ping fallback");
  aclr_cnt_a: assert property (q.ctrl[UPHC_CTRL_ACLR] |=> q.icnt == 16'h0)
    else $error("counter not cleared");
  overrun_flag_zlp_a: assert property (!role_host && xt == UPHC_XT_ISO && rx_i.tok == UPHC_TK_IN
    && !rx_i.pid_err && !rx_i.crc_err && !buf_i.has_data
    |=> resp_o == UPHC_HS_ZLP && not_ready_interrupt_o) else $error("no underrun");
  pid_quiet_a: assert property (xt == UPHC_XT_ISO && rx_i.tok != UPHC_TK_NONE && rx_i.pid_err
    |=> !resp_v_o) else $error("pid error answered");

  nyet_c: cover property (resp_v_o && resp_o == UPHC_HS_NYET);
  ping_out_c: cover property (issue_v_o && issue_o == UPHC_TK_PING ##[1:20]
    issue_v_o && issue_o == UPHC_TK_OUT);
  ival_c: cover property (interval_point_o && issue_v_o);
  overrun_flag_c: cover property (not_ready_interrupt_o);

endmodule : uphc_core

`default_nettype wire

// ===== tb/uphc_far_end.sv
// far-end controller model answering host-issued tokens
`timescale 1ns/100ps
`default_nettype none
module uphc_far_end import uphc_pkg::*; (
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // host side tokens and answer choice
  input  wire logic     issue_v_i,
  input  wire uphc_hs_e ans_i,
  input  wire logic     slow_i,
  // handshake back
  output logic [2:0]    hs_o
);
  // ****************************************
  // answer next cycle, or three cycles late
  // ****************************************
  logic [2:0] d1_q, d2_q, d3_q;
  always_ff @(posedge clk_i) begin
    d1_q <= (issue_v_i && !rst_i) ? ans_i : UPHC_HS_NONE;
    d2_q <= d1_q;
    d3_q <= d2_q;
  end
  assign hs_o = slow_i ? d3_q : d1_q;
endmodule : uphc_far_end
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the usb pipe handshake control core
`timescale 1ns/100ps
`default_nettype none
module tb_top import uphc_pkg::*;;
  // ****************************************
  // signals
  // ****************************************
  logic        clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        sof = 1'b0, brst = 1'b0, slow = 1'b0, pready, perr, rv, iv, not_ready_interrupt, ipt, err, nr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0]  v;
  logic [2:0]  hs;
  uphc_rx_s    rx = '0;
  uphc_buf_s   bf = '0;
  uphc_hs_e    resp, got, ans = UPHC_HS_NAK;
  uphc_tok_e   itok, last = UPHC_TK_NONE;
  int          fails = 0, n_tests = 0, n_ip = 0, n_is = 0;
  integer      seed = 32'h8ef3a488;

  uphc_core #(.CNT_W(16)) i_uphc_core (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .rx_i(rx), .hs_rx_i(hs), .sof_i(sof),
    .bus_reset_i(brst), .buf_i(bf), .resp_o(resp), .resp_v_o(rv), .issue_o(itok),
    .issue_v_o(iv), .not_ready_interrupt_o(not_ready_interrupt), .interval_point_o(ipt));
  uphc_far_end i_uphc_far_end (.clk_i(clk_i), .rst_i(rst_i), .issue_v_i(iv), .ans_i(ans),
    .slow_i(slow), .hs_o(hs));

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (iv === 1'b1) begin
      last <= itok;
      n_is <= n_is + 1;
    end
    if (ipt === 1'b1) n_ip <= n_ip + 1;
  end
  // ****************************************
  // checks, bus and event tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) fails++;
    q = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic cw(input logic ro, input logic [1:0] ty, input logic di,
                    input logic [1:0] rs, input logic [2:0] ex);
    apb(1'b1, UPHC_CTRL_OFS, (32'(ro) << UPHC_CTRL_ROLE) | (32'(ty) << UPHC_CTRL_TYPE)
        | (32'(di) << UPHC_CTRL_DIR) | (32'(rs) << UPHC_CTRL_RESP)
        | (32'(ex) << UPHC_CTRL_ACLR), rd);
  endtask : cw
  task automatic st(input int b);
    apb(1'b0, UPHC_STAT_OFS, 32'h0, rd);
    chk(rd[b], 1'b1);
  endtask : st
  task automatic tok(input uphc_rx_s r);
    got = UPHC_HS_NONE;
    nr = 1'b0;
    @(posedge clk_i) rx <= r;
    @(posedge clk_i) rx <= '0;
    repeat (3) @(posedge clk_i) begin
      if (rv === 1'b1) got = resp;
      if (not_ready_interrupt === 1'b1) nr = 1'b1;
    end
  endtask : tok
  task automatic sofs(input int n, input int eip, input int eis);
    n_ip = 0;
    n_is = 0;
    repeat (n) begin
      @(posedge clk_i) sof <= 1'b1;
      @(posedge clk_i) sof <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    chk(n_ip, eip);
    chk(n_is, eis);
  endtask : sofs
  task automatic run(input uphc_hs_e a, input uphc_tok_e e);
    ans <= a;
    repeat (8) @(posedge clk_i);
    chk(last, e);
  endtask : run
  // v: [1:0] token, [2] short, [3] interrupt, [5:4] response, [8:6] buffer
  function automatic uphc_hs_e exp_hs(input logic [8:0] v);
    if (v[1:0] == 2'h0) return UPHC_HS_ACK;
    if (v[3] && v[1:0] == 2'h3) return UPHC_HS_NONE;
    if (v[5:4] == 2'h0) return UPHC_HS_NAK;
    if (v[5:4] == 2'h2) return UPHC_HS_STALL;
    if (v[1:0] == 2'h1) return v[6] ? UPHC_HS_DATA : UPHC_HS_NAK;
    if (!(v[8] | v[7])) return UPHC_HS_NAK;
    if (v[1:0] == 2'h3 || v[8] || v[2] || v[3]) return UPHC_HS_ACK;
    return UPHC_HS_NYET;
  endfunction : exp_hs
  // ****************************************
  // watchdog and main sequence
  // ****************************************
  initial begin : watchdog
    #200000;
    fails++;
    results();
  end
  initial begin : main
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(1'b0, UPHC_PERI_OFS, 32'h0, rd);
    chk(rd, 32'(UPHC_INTERVAL_EXPONENT_RST));
    apb(1'b0, UPHC_STAT_OFS, 32'h0, rd);
    chk(rd, 32'h10);
    apb(1'b0, UPHC_MAX_PACKET_SIZE_FIELD_OFS, 32'h0, rd);
    chk(rd, 32'(UPHC_MAX_PACKET_SIZE_FIELD_RST));
    apb(1'b1, UPHC_MAX_PACKET_SIZE_FIELD_OFS, 32'(UPHC_SPLIT_MAX_PACKET_SIZE_FIELD_MAX), rd);
    apb(1'b0, UPHC_MAX_PACKET_SIZE_FIELD_OFS, 32'h0, rd);
    chk(rd, 32'(UPHC_SPLIT_MAX_PACKET_SIZE_FIELD_MAX));
    apb(1'b1, UPHC_MAX_PACKET_SIZE_FIELD_OFS, 32'(UPHC_MAX_PACKET_SIZE_FIELD_RST), rd);
    apb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    for (int i = 0; i < 80; i++) begin
      v = (i == 0) ? 9'h092 : (i == 1) ? 9'h096 : (i == 2) ? 9'h19b : 9'($random(seed));
      cw(1'b0, {1'b0, v[3]}, 1'b0, (v[5:4] == 2'h3) ? 2'h1 : v[5:4], 3'h0);
      bf <= '{v[8], v[8] | v[7], v[6]};
      tok('{uphc_tok_e'(3'h1 + 3'(v[1:0])), v[2], 1'b0, 1'b0, 11'h010});
      chk(got, exp_hs(v));
    end
    bf <= '{1'b1, 1'b1, 1'b1};
    cw(1'b1, 2'h0, 1'b0, 2'h1, 3'h0);
    run(UPHC_HS_NAK, UPHC_TK_PING);
    run(UPHC_HS_ACK, UPHC_TK_OUT);
    slow <= 1'b1;
    run(UPHC_HS_NAK, UPHC_TK_PING);
    slow <= 1'b0;
    run(UPHC_HS_ACK, UPHC_TK_OUT);
    run(UPHC_HS_NYET, UPHC_TK_PING);
    for (int j = 0; j < 2; j++) begin
      run(UPHC_HS_ACK, UPHC_TK_OUT);
      bf <= '{1'b1, 1'b1, 1'b0};
      cw(1'b1, 2'h0, 1'b0, 2'h1, j ? 3'h1 : 3'h2);
      cw(1'b1, 2'h0, 1'b0, 2'h1, 3'h0);
      st(UPHC_STAT_PING);
      bf <= '{1'b1, 1'b1, 1'b1};
    end
    for (int e = 0; e < 4; e++) begin
      ans <= e[0] ? UPHC_HS_NYET : UPHC_HS_ACK;
      apb(1'b1, UPHC_PERI_OFS, 32'(e), rd);
      cw(1'b1, 2'h1, 1'b0, 2'h1, 3'h1);
      cw(1'b1, 2'h1, 1'b0, 2'h1, 3'h4);
      sofs(4 << e, 4, 4);
      chk(last, UPHC_TK_OUT);
    end
    cw(1'b1, 2'h1, 1'b0, 2'h0, 3'h4);
    sofs(16, 2, 0);
    bf <= '{1'b0, 1'b0, 1'b0};
    for (int d = 0; d < 2; d++) begin
      cw(1'b1, 2'h1, d[0], 2'h1, 3'h4);
      sofs(16, 2, 0);
    end
    bf <= '{1'b1, 1'b1, 1'b1};
    cw(1'b1, 2'h1, 1'b0, 2'h1, 3'h4);
    sofs(4, 0, 0);
    brst <= 1'b1;
    sofs(8, 0, 0);
    brst <= 1'b0;
    cw(1'b1, 2'h1, 1'b0, 2'h1, 3'h0);
    sofs(8, 0, 0);
    cw(1'b1, 2'h1, 1'b0, 2'h1, 3'h4);
    sofs(4, 1, 1);
    bf <= '{1'b0, 1'b0, 1'b0};
    cw(1'b0, 2'h2, 1'b0, 2'h1, 3'h0);
    tok('{UPHC_TK_OUT, 1'b0, 1'b1, 1'b1, 11'h010});
    chk({got, nr}, 4'h0);
    tok('{UPHC_TK_OUT, 1'b0, 1'b0, 1'b1, 11'h010});
    chk({got, nr}, 4'h0);
    bf <= '{1'b1, 1'b1, 1'b0};
    tok('{UPHC_TK_OUT, 1'b0, 1'b0, 1'b0, 11'h041});
    st(UPHC_STAT_MXOV);
    cw(1'b0, 2'h2, 1'b1, 2'h1, 3'h0);
    apb(1'b1, UPHC_STAT_OFS, 32'h1f, rd);
    tok('{UPHC_TK_IN, 1'b0, 1'b0, 1'b0, 11'h000});
    chk({got, nr}, {UPHC_HS_ZLP, 1'b1});
    st(UPHC_STAT_OVERRUN_FLAG);
    results();
  end
endmodule : tb_top
`default_nettype wire
